// >>> design/magnetic_threshold_event_detector.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// magnetic threshold event detector
// ==========================================================================
// Summary of operation
// (RULE1) event-active flag set when the selected combination of axis flags holds
// (RULE2) source shows current event, or latched event until cleared by a read
// (RULE3) each axis has a high-event flag, one when that axis detected
// (RULE4) each axis polarity flag: zero positive field, one negative field
// (RULE5) axis flags read zero while that axis detection is disabled
// (RULE6) thresholds are unsigned 15-bit values at 0.1 uT per count
// (RULE7) with raw select low, samples have the offset subtracted first
// (RULE8) threshold bits 14..8 in high byte low bits, 7..0 in low byte
// (RULE9) x high byte top bit one: counter clears when condition fails
// (RULE10) mode bit zero: counter decrements by one when condition fails
// (RULE11) event flag set when counter reaches the programmed 8-bit count
// (RULE12) counter saturates at the programmed count
// (RULE13) counter steps once per sample, every second sample in hybrid mode
// (RULE14) logic bit zero: all enabled at or below; one: any at or above
// (RULE15) latch on: flag holds until source read; off: follows detection
// (RULE16) enabled event drives first irq if route bit one, else second
// (RULE17) counter increments while condition holds; reserved bits read zero
module magnetic_threshold_event_detector
    import mag_ths_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [REG_W-1:0]    reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [REG_W-1:0]    reg_rdata_r,
    input  wire logic                sample_tick,
    input  wire logic [SAMPLE_W-1:0] sample_x,
    input  wire logic [SAMPLE_W-1:0] sample_y,
    input  wire logic [SAMPLE_W-1:0] sample_z,
    input  wire logic [SAMPLE_W-1:0] offset_x,
    input  wire logic [SAMPLE_W-1:0] offset_y,
    input  wire logic [SAMPLE_W-1:0] offset_z,
    input  wire logic                raw_output_sel,
    input  wire logic [1:0]          sensor_select,
    output logic                     event_active_flag,
    output logic                     first_irq_output,
    output logic                     second_irq_output
);

    // ======================================================================
    // registers
    // ======================================================================
    logic [REG_W-1:0] cfg_r;
    logic             db_mode_r;
    logic [THS_W-1:0] ths_x_r;
    logic [THS_W-1:0] ths_y_r;
    logic [THS_W-1:0] ths_z_r;
    logic [REG_W-1:0] count_limit_r;
    logic [REG_W-1:0] src_r;
    src_state_t       src_state_r;
    logic             step_phase_r;

    logic             wr_cfg;
    logic             wr_x_high;
    logic             wr_x_low;
    logic             wr_y_high;
    logic             wr_y_low;
    logic             wr_z_high;
    logic             wr_z_low;
    logic             wr_count;
    logic             src_read;

    logic             step;
    logic             hybrid;
    logic [2:0]       en;
    logic [2:0]       above;
    logic [2:0]       below;
    logic [2:0]       neg;
    logic [2:0]       axis_he;
    logic             cond;
    logic             hit;
    logic [REG_W-1:0] src_new;
    logic [REG_W-1:0] src_view;
    logic [REG_W-1:0] rd_mux;

    // ======================================================================
    // register decode
    // ======================================================================
    assign wr_cfg    = reg_wr && (reg_addr == ADDR_CFG);
    assign wr_x_high = reg_wr && (reg_addr == ADDR_X_HIGH);
    assign wr_x_low  = reg_wr && (reg_addr == ADDR_X_LOW);
    assign wr_y_high = reg_wr && (reg_addr == ADDR_Y_HIGH);
    assign wr_y_low  = reg_wr && (reg_addr == ADDR_Y_LOW);
    assign wr_z_high = reg_wr && (reg_addr == ADDR_Z_HIGH);
    assign wr_z_low  = reg_wr && (reg_addr == ADDR_Z_LOW);
    assign wr_count  = reg_wr && (reg_addr == ADDR_COUNT);
    assign src_read  = reg_rd && (reg_addr == ADDR_SRC);

    // configuration byte, all fields software owned
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_r <= REG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= reg_wdata;
        end
    end

    // thresholds split over high and low bytes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ths_x_r   <= THS_RESET;
            ths_y_r   <= THS_RESET;
            ths_z_r   <= THS_RESET;
            db_mode_r <= 1'b0;
        end else begin
            if (wr_x_high) begin
                ths_x_r[THS_W-1:REG_W] <= reg_wdata[HI_W-1:0];   // RULE8
                db_mode_r              <= reg_wdata[DB_MODE_BIT]; // RULE9
            end
            if (wr_x_low) begin
                ths_x_r[REG_W-1:0] <= reg_wdata;                  // RULE8
            end
            if (wr_y_high) begin
                ths_y_r[THS_W-1:REG_W] <= reg_wdata[HI_W-1:0];   // RULE17
            end
            if (wr_y_low) begin
                ths_y_r[REG_W-1:0] <= reg_wdata;
            end
            if (wr_z_high) begin
                ths_z_r[THS_W-1:REG_W] <= reg_wdata[HI_W-1:0];   // RULE17
            end
            if (wr_z_low) begin
                ths_z_r[REG_W-1:0] <= reg_wdata;                  // RULE6
            end
        end
    end

    // debounce count limit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_limit_r <= REG_RESET;
        end else if (wr_count) begin
            count_limit_r <= reg_wdata;
        end
    end

    // ======================================================================
    // sample step, halved in hybrid mode
    // ======================================================================
    assign hybrid = (sensor_select == HMS_HYBRID);

    // phase bit skips every other tick; restarts when leaving hybrid
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            step_phase_r <= 1'b0;
        end else if (!hybrid) begin
            step_phase_r <= 1'b0;
        end else if (sample_tick) begin
            step_phase_r <= ~step_phase_r;                        // RULE13
        end
    end

    assign step = sample_tick && (!hybrid || step_phase_r);      // RULE13

    // ======================================================================
    // per-axis compare
    // ======================================================================
    assign en = {cfg_r[CFG_Z_EN], cfg_r[CFG_Y_EN], cfg_r[CFG_X_EN]};

    axis_compare u_cmp_x (
        .raw_sample  (sample_x),
        .offset_word (offset_x),
        .raw_sel     (raw_output_sel),
        .threshold   (ths_x_r),
        .at_or_above (above[0]),
        .at_or_below (below[0]),
        .negative    (neg[0])
    );

    axis_compare u_cmp_y (
        .raw_sample  (sample_y),
        .offset_word (offset_y),
        .raw_sel     (raw_output_sel),
        .threshold   (ths_y_r),
        .at_or_above (above[1]),
        .at_or_below (below[1]),
        .negative    (neg[1])
    );

    axis_compare u_cmp_z (
        .raw_sample  (sample_z),
        .offset_word (offset_z),
        .raw_sel     (raw_output_sel),
        .threshold   (ths_z_r),
        .at_or_above (above[2]),
        .at_or_below (below[2]),
        .negative    (neg[2])
    );

    // and of enabled below, or or of enabled above; no axis, no event
    always_comb begin
        if (cfg_r[CFG_OR_ABOVE]) begin
            axis_he = en & above;
            cond    = |axis_he;                                   // RULE14
        end else begin
            axis_he = en & below;
            cond    = (|en) && ((below | ~en) == 3'h7);           // RULE14
        end
    end

    debounce_counter u_debounce (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .step       (step),
        .cond       (cond),
        .clear_mode (db_mode_r),
        .limit      (count_limit_r),
        .hit        (hit)
    );

    // ======================================================================
    // source register
    // ======================================================================
    // snapshot of the event being reported at this step
    always_comb begin
        src_new = READ_ZERO;
        if (hit) begin
            src_new[SRC_ACTIVE] = 1'b1;                           // RULE1
            src_new[SRC_X_HE]   = axis_he[0];                     // RULE3
            src_new[SRC_X_HP]   = axis_he[0] && neg[0];           // RULE4
            src_new[SRC_Y_HE]   = axis_he[1];
            src_new[SRC_Y_HP]   = axis_he[1] && neg[1];
            src_new[SRC_Z_HE]   = axis_he[2];
            src_new[SRC_Z_HP]   = axis_he[2] && neg[2];
        end
    end

    // tracking follows every step; held waits for a source read.
    // a new event in the read cycle wins over the clear.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_r       <= REG_RESET;
            src_state_r <= SRC_TRACK;
        end else begin
            case (src_state_r)
                SRC_TRACK: begin
                    if (step) begin
                        src_r <= src_new;                         // RULE2
                        if (cfg_r[CFG_LATCH] && hit) begin
                            src_state_r <= SRC_HELD;              // RULE15
                        end
                    end
                end
                SRC_HELD: begin
                    if (step && hit) begin
                        src_r <= src_new;
                    end else if (src_read) begin
                        src_r       <= step ? src_new : READ_ZERO; // RULE15
                        src_state_r <= SRC_TRACK;
                    end else if (!cfg_r[CFG_LATCH]) begin
                        src_state_r <= SRC_TRACK;
                    end
                end
                default: begin
                    src_r       <= REG_RESET;
                    src_state_r <= SRC_TRACK;
                end
            endcase
        end
    end

    // disabled axes always read zero, reserved bit too
    always_comb begin
        src_view           = src_r;
        src_view[SRC_X_HE] = src_r[SRC_X_HE] && en[0];            // RULE5
        src_view[SRC_X_HP] = src_r[SRC_X_HP] && en[0];            // RULE5
        src_view[SRC_Y_HE] = src_r[SRC_Y_HE] && en[1];            // RULE5
        src_view[SRC_Y_HP] = src_r[SRC_Y_HP] && en[1];
        src_view[SRC_Z_HE] = src_r[SRC_Z_HE] && en[2];
        src_view[SRC_Z_HP] = src_r[SRC_Z_HP] && en[2];
    end

    // ======================================================================
    // read port, one cycle after the read strobe
    // ======================================================================
    always_comb begin
        case (reg_addr)
            ADDR_CFG:    rd_mux = cfg_r;
            ADDR_SRC:    rd_mux = src_view;
            ADDR_X_HIGH: rd_mux = {db_mode_r, ths_x_r[THS_W-1:REG_W]};
            ADDR_X_LOW:  rd_mux = ths_x_r[REG_W-1:0];
            ADDR_Y_HIGH: rd_mux = {1'b0, ths_y_r[THS_W-1:REG_W]}; // RULE17
            ADDR_Y_LOW:  rd_mux = ths_y_r[REG_W-1:0];
            ADDR_Z_HIGH: rd_mux = {1'b0, ths_z_r[THS_W-1:REG_W]}; // RULE17
            ADDR_Z_LOW:  rd_mux = ths_z_r[REG_W-1:0];
            ADDR_COUNT:  rd_mux = count_limit_r;
            default:     rd_mux = READ_ZERO;
        endcase
    end

    // data holds until the next read strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= REG_RESET;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end
    end

    // ======================================================================
    // event outputs, registered so they never glitch
    // ======================================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            event_active_flag <= 1'b0;
            first_irq_output  <= 1'b0;
            second_irq_output <= 1'b0;
        end else begin
            event_active_flag <= src_r[SRC_ACTIVE];               // RULE1
            first_irq_output  <= src_r[SRC_ACTIVE] && cfg_r[CFG_INT_EN]
                                 && cfg_r[CFG_INT_ROUTE];         // RULE16
            second_irq_output <= src_r[SRC_ACTIVE] && cfg_r[CFG_INT_EN]
                                 && !cfg_r[CFG_INT_ROUTE];        // RULE16
        end
    end

endmodule
`default_nettype wire

// >>> include/mag_ths_pkg.sv
// ==========================================================================
// register map, field layout and mode encodings
// ==========================================================================
package mag_ths_pkg;

    // ======================================================================
    // widths
    // ======================================================================
    localparam int REG_W    = 8;
    localparam int ADDR_W   = 8;
    localparam int THS_W    = 15;
    localparam int SAMPLE_W = 16;
    localparam int CORR_W   = 17;
    localparam int HI_W     = 7;   // threshold bits held in the high byte

    // ======================================================================
    // register offsets
    // ======================================================================
    localparam logic [ADDR_W-1:0] ADDR_CFG    = 8'h52;
    localparam logic [ADDR_W-1:0] ADDR_SRC    = 8'h53;
    localparam logic [ADDR_W-1:0] ADDR_X_HIGH = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_X_LOW  = 8'h55;
    localparam logic [ADDR_W-1:0] ADDR_Y_HIGH = 8'h56;
    localparam logic [ADDR_W-1:0] ADDR_Y_LOW  = 8'h57;
    localparam logic [ADDR_W-1:0] ADDR_Z_HIGH = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_Z_LOW  = 8'h59;
    localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h5a;

    // ======================================================================
    // reset values
    // ======================================================================
    localparam logic [REG_W-1:0]  REG_RESET  = 8'h00;
    localparam logic [THS_W-1:0]  THS_RESET  = 15'h0000;
    localparam logic [REG_W-1:0]  READ_ZERO  = 8'h00;

    // ======================================================================
    // configuration register bit positions
    // ======================================================================
    localparam int CFG_LATCH     = 7;
    localparam int CFG_OR_ABOVE  = 6;
    localparam int CFG_Z_EN      = 5;
    localparam int CFG_Y_EN      = 4;
    localparam int CFG_X_EN      = 3;
    localparam int CFG_WAKE_EN   = 2;
    localparam int CFG_INT_EN    = 1;
    localparam int CFG_INT_ROUTE = 0;

    // ======================================================================
    // source register bit positions
    // ======================================================================
    localparam int SRC_ACTIVE = 7;
    localparam int SRC_Z_HE   = 5;
    localparam int SRC_Z_HP   = 4;
    localparam int SRC_Y_HE   = 3;
    localparam int SRC_Y_HP   = 2;
    localparam int SRC_X_HE   = 1;
    localparam int SRC_X_HP   = 0;

    // debounce mode bit in the x high byte
    localparam int DB_MODE_BIT = 7;

    // ======================================================================
    // sensor selection encodings
    // ======================================================================
    localparam logic [1:0] HMS_MAG_ONLY = 2'h1;
    localparam logic [1:0] HMS_HYBRID   = 2'h3;

    // source register tracking state
    typedef enum logic [1:0] {
        SRC_TRACK = 2'h1,
        SRC_HELD  = 2'h2
    } src_state_t;

endpackage

// >>> design/axis_compare.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// per-axis offset correction and threshold compare
// ==========================================================================
module axis_compare
    import mag_ths_pkg::*;
(
    input  wire logic [SAMPLE_W-1:0] raw_sample,
    input  wire logic [SAMPLE_W-1:0] offset_word,
    input  wire logic                raw_sel,
    input  wire logic [THS_W-1:0]    threshold,
    output logic                     at_or_above,
    output logic                     at_or_below,
    output logic                     negative
);

    logic signed [CORR_W-1:0] sample_ext;
    logic signed [CORR_W-1:0] offset_ext;
    logic signed [CORR_W-1:0] corrected;
    logic        [CORR_W-1:0] magnitude;
    logic        [CORR_W-1:0] ths_ext;

    // offset lives in the upper 15 bits, so shift it down and sign extend
    always_comb begin
        sample_ext = {raw_sample[SAMPLE_W-1], raw_sample};
        offset_ext = {{2{offset_word[SAMPLE_W-1]}},
                      offset_word[SAMPLE_W-1:1]};
        corrected  = raw_sel ? sample_ext
                             : CORR_W'(sample_ext - offset_ext); // RULE7
        magnitude  = corrected[CORR_W-1] ? CORR_W'(-corrected)
                                         : corrected;
        ths_ext    = CORR_W'(threshold);
    end

    // compare field magnitude against the unsigned threshold
    assign at_or_above = (magnitude >= ths_ext);     // RULE14
    assign at_or_below = (magnitude <= ths_ext);     // RULE14
    assign negative    = corrected[CORR_W-1];        // RULE4

endmodule
`default_nettype wire

// >>> design/debounce_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// saturating debounce counter, one step per sample, every second sample in hybrid
// ==========================================================================
module debounce_counter
    import mag_ths_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             step,
    input  wire logic             cond,
    input  wire logic             clear_mode,
    input  wire logic [REG_W-1:0] limit,
    output logic                  hit
);

    logic [REG_W-1:0] count_r;
    logic [REG_W-1:0] count_nxt;

    // next count; clamps if software lowers the limit under the count
    always_comb begin
        if (cond) begin
            if (count_r >= limit) begin
                count_nxt = limit;                         // RULE12
            end else begin
                count_nxt = REG_W'(count_r + 1'b1);        // RULE17
            end
        end else if (clear_mode) begin
            count_nxt = REG_W'(0);                         // RULE9
        end else if (count_r == REG_W'(0)) begin
            count_nxt = REG_W'(0);
        end else begin
            count_nxt = REG_W'(count_r - 1'b1);            // RULE10
        end
    end

    // counter only moves on a sample step
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_r <= REG_RESET;
        end else if (step) begin
            count_r <= count_nxt;                          // RULE13
        end
    end

    // event once the count reaches the programmed limit
    assign hit = step && cond && (count_nxt == limit);     // RULE11

endmodule
`default_nettype wire

// >>> tb/mag_ths_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port checker for the threshold event detector
// ==========================================================================
module mag_ths_checker
    import mag_ths_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0]  reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [REG_W-1:0]  reg_rdata_r,
    input wire logic              sample_tick,
    input wire logic              event_active_flag,
    input wire logic              first_irq_output,
    input wire logic              second_irq_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] cause_r;
    // recent steps and accesses; only these may drop the flag
    always_ff @(posedge ref_clk) begin
        cause_r <= {cause_r[1:0], sample_tick | reg_rd | reg_wr};
    end
    a_irq_one_pin: assert property (first_irq_output |-> !second_irq_output)
        else $error("both irq outputs high");
    a_irq_quiet: assert property (!event_active_flag &&
        !$past(event_active_flag) |-> !first_irq_output && !second_irq_output)
        else $error("irq without event flag");
    a_unmapped_zero: assert property ($past(reg_rd) &&
        ($past(reg_addr) < ADDR_CFG || $past(reg_addr) > ADDR_COUNT)
        |-> reg_rdata_r == READ_ZERO) else $error("unmapped read not zero");
    a_src_reserved: assert property ($past(reg_rd) &&
        $past(reg_addr) == ADDR_SRC |-> reg_rdata_r[6] == 1'b0)
        else $error("source reserved bit set");
    a_yz_reserved: assert property ($past(reg_rd) &&
        ($past(reg_addr) == ADDR_Y_HIGH || $past(reg_addr) == ADDR_Z_HIGH)
        |-> reg_rdata_r[7] == 1'b0) else $error("high byte reserved bit set");
    a_flag_from_step: assert property ($rose(event_active_flag)
        |-> $past(sample_tick, 2)) else $error("flag rose without a step");
    a_flag_drop_cause: assert property ($fell(event_active_flag)
        |-> cause_r != 3'h0) else $error("flag fell without a cause");
    a_low_readback: assert property ($past(reg_wr, 3) && $past(reg_rd) &&
        $past(reg_addr, 3) == ADDR_X_LOW && $past(reg_addr) == ADDR_X_LOW
        |-> reg_rdata_r == $past(reg_wdata, 3)) else $error("low byte lost");
    c_flag_rise: cover property ($rose(event_active_flag));
    c_first_irq: cover property (first_irq_output);
    c_second_irq: cover property (second_irq_output);
endmodule
bind magnetic_threshold_event_detector mag_ths_checker chk_u (.*);
`default_nettype wire

// >>> tb/reg_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host side of the register strobes
// ==========================================================================
module reg_host
    import mag_ths_pkg::*;
(
    input  wire logic              ref_clk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [REG_W-1:0]  reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [REG_W-1:0]  reg_rdata_r
);
    // idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // single-edge write; address and data held with the strobe
    task automatic wr(input logic [REG_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data is registered, so taken one edge after the strobe
    task automatic rd(input logic [REG_W-1:0] a, output logic [REG_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata_r;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the threshold event detector
// ==========================================================================
module tb
    import mag_ths_pkg::*;
;
    logic ref_clk, rst_n, reg_wr, reg_rd, sample_tick, raw_output_sel;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
    logic [15:0] sample_x, sample_y, sample_z, offset_x, offset_y, offset_z;
    logic [1:0] sensor_select;
    logic event_active_flag, first_irq_output, second_irq_output;
    int fails = 0;
    int comparisons = 0;
    magnetic_threshold_event_detector dut_u (.*);
    reg_host host_u (.*);
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // flag, first irq, second irq
    task automatic flags(logic [2:0] e);
        chk("flags", {5'h0, e}, {5'h0, event_active_flag,
            first_irq_output, second_irq_output});
    endtask
    task automatic rdchk(logic [7:0] a, logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        chk("register", e, d);
    endtask
    // one sample step, then the flag settles
    task automatic tick(logic [15:0] v);
        @(posedge ref_clk);
        sample_x <= v;
        sample_tick <= 1'b1;
        @(posedge ref_clk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic cfg(logic [7:0] c, logic [7:0] l, logic [7:0] h);
        host_u.wr(ADDR_CFG, c);
        host_u.wr(ADDR_COUNT, l);
        host_u.wr(ADDR_X_HIGH, h);
        host_u.wr(ADDR_X_LOW, 8'h64);
    endtask
    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_regs();
        for (int a = 'h52; a <= 'h5a; a++) rdchk(8'(a), 8'h00);
        rdchk(8'h60, 8'h00);
        for (int a = 'h53; a <= 'h5a; a++) begin
            host_u.wr(8'(a), 8'hff);
            rdchk(8'(a), a == 'h53 ? 8'h00 :
                (a == 'h56 || a == 'h58) ? 8'h7f : 8'hff);
        end
    endtask
    task automatic t_or_above();
        cfg(8'h4b, 8'h00, 8'h00);
        tick(16'hff9c);
        flags(3'b110);
        rdchk(ADDR_SRC, 8'h83);
        tick(16'h0032);
        flags(3'b000);
        host_u.wr(ADDR_CFG, 8'h4a);
        tick(16'h0064);
        flags(3'b101);
        rdchk(ADDR_SRC, 8'h82);
    endtask
    task automatic t_and_below();
        cfg(8'h18, 8'h00, 8'h00);
        host_u.wr(ADDR_Y_HIGH, 8'h00);
        host_u.wr(ADDR_Y_LOW, 8'h64);
        sample_y <= 16'h0064;
        tick(16'hff9c);
        flags(3'b100);
        rdchk(ADDR_SRC, 8'h8b);
        host_u.wr(ADDR_CFG, 8'h08);
        rdchk(ADDR_SRC, 8'h83);
    endtask
    task automatic t_raw();
        cfg(8'h48, 8'h00, 8'h00);
        raw_output_sel <= 1'b0;
        tick(16'h0096);
        flags(3'b000);
        raw_output_sel <= 1'b1;
        tick(16'h0096);
        flags(3'b100);
    endtask
    // pattern F F F T T F T T against a count of three
    task automatic t_debounce();
        logic [7:0] pat = 8'b0001_1011;
        for (int m = 0; m < 2; m++) begin
            host_u.wr(ADDR_X_HIGH, {m[0], 7'h00});
            host_u.wr(ADDR_COUNT, 8'h03);
            for (int i = 7; i >= 0; i--) tick(pat[i] ? 16'h0064 : 16'h0000);
            flags(m == 0 ? 3'b100 : 3'b000);
        end
    endtask
    // entry tick into hybrid does not step the counter
    task automatic t_hybrid();
        host_u.wr(ADDR_COUNT, 8'h00);
        tick(16'h0000);
        sensor_select <= HMS_HYBRID;
        tick(16'h0064);
        flags(3'b000);
        tick(16'h0064);
        flags(3'b100);
        sensor_select <= HMS_MAG_ONLY;
    endtask
    task automatic t_latch();
        cfg(8'hc8, 8'h00, 8'h00);
        tick(16'h0064);
        tick(16'h0000);
        flags(3'b100);
        rdchk(ADDR_SRC, 8'h82);
        repeat (2) @(posedge ref_clk);
        flags(3'b000);
    endtask
    // reset held for six cycles
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {sample_tick, sample_x, sample_y, offset_y, offset_z} = '0;
        sample_z = 16'h7000;
        offset_x = 16'h00c8;
        raw_output_sel = 1'b1;
        sensor_select = HMS_MAG_ONLY;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_or_above();
        t_and_below();
        t_raw();
        t_debounce();
        t_hybrid();
        t_latch();
        test_done();
    end
    // guard against a hang
    initial begin
        #5_000_000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
